// ===== rtl/hcw_pkg.sv
// constants shared by the host communication watchdog files
// assumes a 200 MHz core clock and one-cycle register access strobes
package hcw_pkg;
	// core clock and timebase
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned OSC_HZ = 1228800;
	localparam int unsigned OSC_DIV = 1024;
	localparam int unsigned TICK_HZ = OSC_HZ / OSC_DIV;
	localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / TICK_HZ;
	localparam int DIV_W = 18;
	// watchdog configuration field positions
	localparam int EN_POS = 0;
	localparam int LO_POS = 1;
	localparam int UP_POS = 3;
	localparam int CFG_W = 16;
	// values after reset
	localparam logic EN_RST = 1'b0;
	localparam logic [1:0] LO_RST = 2'h0;
	localparam logic [2:0] UP_RST = 3'h0;
	// tick counter and limit scaling, in 1200 Hz ticks
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] UP_UNIT_TICKS = 8'h08;
	localparam logic [7:0] LO_UNIT_TICKS = 8'h02;
	localparam logic [1:0] LO_TIMEOUT_MODE = 2'h0;
endpackage : hcw_pkg

// ===== rtl/hcw_tick_if.sv
// carries the 1200 Hz timebase tick between the divider and the watchdog
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface hcw_tick_if;
	logic tick;
	modport src (output tick);
	modport dst (input tick);
endinterface : hcw_tick_if

// ===== rtl/hcw_tick_div.sv
// divider making the one-cycle 1200 Hz watchdog tick from the core clock
// assumes an active-low asynchronous reset and a shared clock enable
`timescale 1ns/1ps
module hcw_tick_div #(
	parameter int unsigned TICK_CYCLES = hcw_pkg::TICK_CYCLES_DEF
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	hcw_tick_if.src tick_if
);
	import hcw_pkg::*;

	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

	logic [DIV_W-1:0] div_reg;
	logic [DIV_W-1:0] div_next;
	logic tick_reg;
	logic tick_next;

	// wrap counter, pulse once per period
	always_comb begin
		div_next = div_reg;
		tick_next = tick_reg;
		if (clk_en_in) begin
			tick_next = (div_reg == DIV_LAST);
			div_next = (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
		end
	end

	// registers only
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_if.tick = tick_reg;
endmodule : hcw_tick_div

// ===== rtl/hcw_watchdog.sv
// host communication window watchdog: timeout or window supervision
// assumes write strobes are one-cycle pulses from the same clock domain
//
// Overview of operation
// RULE_01 - watchdog stays idle and raises no error until enable is 1
// RULE_02 - spi and uart break mode writes both count as host activity
// RULE_03 - nonzero lower limit: write too early or too late is an error
// RULE_04 - window mode after error restarts only on config register write
// RULE_05 - lower limit zero: any write restarts counter, error past upper
// RULE_06 - host must write inside the programmed window each period
// RULE_07 - error drives fault pin low and sets the fault flag
// RULE_08 - flag is sticky; writing enable 0 clears the fault condition
// RULE_09 - software or hardware reset also clears the fault condition
// RULE_10 - with condition clear, reading fault status clears the flag
// RULE_11 - limits are timed from a 1200 Hz tick, oscillator over 1024
// RULE_12 - config holds 3-bit upper, 2-bit lower limit and enable bit
// RULE_13 - counter restarts from zero when enable goes from 0 to 1
`timescale 1ns/1ps
module hcw_watchdog #(
	parameter int unsigned TICK_CYCLES = hcw_pkg::TICK_CYCLES_DEF
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic clk_en_in,
	input wire logic spi_write_in,
	input wire logic uart_break_mode_write_in,
	input wire logic cfg_write_in,
	input wire logic [hcw_pkg::CFG_W-1:0] cfg_data_in,
	input wire logic sw_reset_in,
	input wire logic status_read_in,
	output logic watchdog_enable_out,
	output logic [2:0] upper_limit_sel_out,
	output logic [1:0] lower_limit_sel_out,
	output logic watchdog_fault_flag_out,
	output logic fault_n_out
);
	import hcw_pkg::*;

	// limit in ticks for an upper selection
	function automatic logic [CNT_W-1:0] up_limit(input logic [2:0] sel);
		up_limit = ({5'h00, sel} + 8'h01) * UP_UNIT_TICKS;
	endfunction : up_limit

	// limit in ticks for a lower selection
	function automatic logic [CNT_W-1:0] lo_limit(input logic [1:0] sel);
		lo_limit = {6'h00, sel} * LO_UNIT_TICKS;
	endfunction : lo_limit

	hcw_tick_if tick_if ();

	hcw_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_tick_div (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.clk_en_in(clk_en_in),
		.tick_if(tick_if)
	);

	logic en_reg, en_next;
	logic [2:0] up_reg, up_next;
	logic [1:0] lo_reg, lo_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic halt_reg, halt_next;
	logic cond_reg, cond_next;
	logic flag_reg, flag_next;
	logic fault_n_reg, fault_n_next;
	logic host_wr;
	logic window;
	logic early;
	logic late;
	logic err;

	// host activity and error detection
	always_comb begin
		host_wr = spi_write_in | uart_break_mode_write_in; // see RULE_02
		window = (lo_reg != LO_TIMEOUT_MODE);
		early = host_wr & window & (cnt_reg < lo_limit(lo_reg)); // see RULE_03
		late = (cnt_reg > up_limit(up_reg)); // see RULE_05
		err = clk_en_in & en_reg & ~halt_reg & (early | late); // see RULE_01
	end

	// next state of configuration, counter and fault
	always_comb begin
		en_next = en_reg;
		up_next = up_reg;
		lo_next = lo_reg;
		cnt_next = cnt_reg;
		halt_next = halt_reg;
		cond_next = cond_reg;
		flag_next = flag_reg;
		if (clk_en_in) begin
			if (sw_reset_in) begin
				en_next = EN_RST;
				up_next = UP_RST;
				lo_next = LO_RST;
			end else if (cfg_write_in) begin
				en_next = cfg_data_in[EN_POS]; // see RULE_12
				up_next = cfg_data_in[UP_POS +: 3]; // see RULE_12
				lo_next = cfg_data_in[LO_POS +: 2]; // see RULE_12
			end
			if (!en_reg || (en_next && !en_reg)) begin
				cnt_next = '0; // see RULE_13
			end else if (halt_reg) begin
				if (cfg_write_in) begin
					cnt_next = '0; // see RULE_04
				end
			end else if (host_wr && (!window || !err)) begin
				cnt_next = '0; // see RULE_05
			end else if (tick_if.tick && cnt_reg != CNT_MAX) begin
				cnt_next = cnt_reg + 1'b1; // see RULE_11
			end
			if (!en_next || cfg_write_in) begin
				halt_next = 1'b0; // see RULE_04
			end else if (err && window) begin
				halt_next = 1'b1; // see RULE_04
			end
			// see RULE_08 see RULE_09
			cond_next = (cond_reg | err) & en_next & ~sw_reset_in;
			// set wins over the read clear; see RULE_10
			flag_next = err | (flag_reg & ~(status_read_in & ~cond_reg));
		end
		fault_n_next = ~cond_next; // see RULE_07
	end

	// registers only
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			en_reg <= EN_RST;
			up_reg <= UP_RST;
			lo_reg <= LO_RST;
			cnt_reg <= '0;
			halt_reg <= 1'b0;
			cond_reg <= 1'b0;
			flag_reg <= 1'b0;
			fault_n_reg <= 1'b1;
		end else begin
			en_reg <= en_next;
			up_reg <= up_next;
			lo_reg <= lo_next;
			cnt_reg <= cnt_next;
			halt_reg <= halt_next;
			cond_reg <= cond_next;
			flag_reg <= flag_next; // see RULE_07
			fault_n_reg <= fault_n_next;
		end
	end

	// outputs straight from flip-flops
	assign watchdog_enable_out = en_reg;
	assign upper_limit_sel_out = up_reg;
	assign lower_limit_sel_out = lo_reg;
	assign watchdog_fault_flag_out = flag_reg;
	assign fault_n_out = fault_n_reg;

	// checks on the watchdog behaviour
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	AST_IDLE_NO_FAULT: assert property ( // see RULE_01
		clk_en_in && !en_reg && !cfg_write_in |=> fault_n_out)
		else $error("fault while watchdog disabled");
	AST_WRITE_RESTART: assert property ( // see RULE_02
		clk_en_in && en_reg && !halt_reg && !window && !sw_reset_in &&
		!cfg_write_in && (spi_write_in || uart_break_mode_write_in)
		|=> cnt_reg == 8'h00)
		else $error("host write did not restart counter");
	AST_EARLY_WRITE: assert property ( // see RULE_03
		clk_en_in && en_reg && !halt_reg && early && !sw_reset_in &&
		!(cfg_write_in && !cfg_data_in[EN_POS]) |=> !fault_n_out ##0 flag_reg)
		else $error("early write not flagged");
	AST_HALT_HOLDS: assert property ( // see RULE_04
		clk_en_in && halt_reg && en_reg && !cfg_write_in && !sw_reset_in
		|=> $stable(cnt_reg) && halt_reg)
		else $error("window timing restarted without config write");
	AST_LATE_FAULT: assert property ( // see RULE_05
		clk_en_in && en_reg && !halt_reg && late && !sw_reset_in &&
		!(cfg_write_in && !cfg_data_in[EN_POS]) |=> !fault_n_out)
		else $error("expired counter not flagged");
	AST_PIN_FLAG: assert property ( // see RULE_07
		$fell(fault_n_out) |-> watchdog_fault_flag_out)
		else $error("fault pin low without flag");
	AST_STICKY: assert property ( // see RULE_08
		flag_reg && !(clk_en_in && status_read_in) |=> flag_reg)
		else $error("fault flag lost without read");
	AST_DISABLE_CLEARS: assert property ( // see RULE_08
		clk_en_in && cfg_write_in && !cfg_data_in[EN_POS] |=> fault_n_out)
		else $error("disable did not clear fault");
	AST_SWRST_CLEARS: assert property ( // see RULE_09
		clk_en_in && sw_reset_in |=> fault_n_out && !watchdog_enable_out)
		else $error("software reset did not clear fault");
	AST_READ_CLEARS: assert property ( // see RULE_10
		clk_en_in && status_read_in && !cond_reg && !err |=> !flag_reg)
		else $error("status read did not clear flag");
	AST_COUNT_ON_TICK: assert property ( // see RULE_11
		cnt_reg != 8'h00 && cnt_reg != $past(cnt_reg) |-> $past(tick_if.tick))
		else $error("counter advanced without tick");
	AST_CFG_LOAD: assert property ( // see RULE_12
		clk_en_in && cfg_write_in && !sw_reset_in
		|=> upper_limit_sel_out == $past(cfg_data_in[5:3]) &&
		lower_limit_sel_out == $past(cfg_data_in[2:1]))
		else $error("config fields not loaded");
	AST_ENABLE_START: assert property ( // see RULE_13
		$rose(en_reg) |-> cnt_reg == 8'h00)
		else $error("counter not zero at enable");
	AST_WINDOW_HALT: assert property ( // see RULE_04
		err && window && !cfg_write_in && !sw_reset_in |=> halt_reg)
		else $error("window error did not halt timing");
	AST_FLAG_FROM_ERR: assert property ( // see RULE_07
		!flag_reg && !err |=> !flag_reg)
		else $error("fault flag set without an error");
	// clock enable low holds the counter, condition, flag and enable bits
	AST_FREEZE_HOLD: assert property (
		!clk_en_in |=> $stable(cnt_reg) && $stable(flag_reg) &&
		$stable(cond_reg) && $stable(en_reg))
		else $error("state moved while clock enable low");

	COV_TIMEOUT_FAULT: cover property (en_reg && !window ##1 $fell(fault_n_out));
	COV_WINDOW_EARLY: cover property (err && early);
	COV_FLAG_CLEARED: cover property (flag_reg ##1 !flag_reg);
	// main scenarios of halt release and freeze
	COV_WINDOW_RESTART: cover property (halt_reg && cfg_write_in ##1 !halt_reg);
	COV_FROZEN: cover property (!clk_en_in && en_reg);
endmodule : hcw_watchdog

// ===== tb/hcw_host_model.sv
// host model: register write pulses over spi or uart break mode
// assumes the bench calls write_reg; drives just after falling edges
`timescale 1ns/1ps
module hcw_host_model (
	input wire logic clk_in,
	output logic spi_write_out,
	output logic uart_break_mode_write_out,
	output logic cfg_write_out,
	output logic [15:0] cfg_data_out
);
	// idle lines at time zero
	initial begin
		{spi_write_out, uart_break_mode_write_out, cfg_write_out} = 3'h0;
		cfg_data_out = 16'h0000;
	end
	// one-cycle write, data scrambled once released
	task automatic write_reg(input logic brk, input logic cfg,
		input logic [15:0] data);
		@(negedge clk_in);
		spi_write_out = !brk;
		uart_break_mode_write_out = brk;
		cfg_write_out = cfg;
		cfg_data_out = data;
		@(negedge clk_in);
		{spi_write_out, uart_break_mode_write_out, cfg_write_out} = 3'h0;
		cfg_data_out = ~data;
	endtask : write_reg
endmodule : hcw_host_model

// ===== tb/hcw_watchdog_tb.sv
// bench for the host communication watchdog
// assumes a tick every 4 core cycles and the host model beside it
`timescale 1ns/1ps
module hcw_watchdog_tb;
	import hcw_pkg::*;
	logic clk_in, resetn_in, sw_reset_in, status_read_in, clk_en;
	logic spi_w, brk_w, cfg_w, en, flag, fault_n;
	logic [15:0] cfg_d;
	logic [2:0] up;
	logic [1:0] lo;
	int bad_count, compares, n;
	hcw_host_model host (.clk_in(clk_in), .spi_write_out(spi_w),
		.uart_break_mode_write_out(brk_w), .cfg_write_out(cfg_w),
		.cfg_data_out(cfg_d));
	hcw_watchdog #(.TICK_CYCLES(4)) DUT (.clk_in(clk_in),
		.resetn_in(resetn_in), .clk_en_in(clk_en), .spi_write_in(spi_w),
		.uart_break_mode_write_in(brk_w), .cfg_write_in(cfg_w),
		.cfg_data_in(cfg_d),
		.sw_reset_in(sw_reset_in), .status_read_in(status_read_in),
		.watchdog_enable_out(en), .upper_limit_sel_out(up),
		.lower_limit_sel_out(lo), .watchdog_fault_flag_out(flag),
		.fault_n_out(fault_n));
	// clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	task automatic conclude();
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	task automatic check(input logic [15:0] seen, exp, input string m);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s %h/%h", $time, m, seen, exp);
		end
	endtask : check
	// one-cycle strobe: read status or software reset
	task automatic strobe(input logic rd);
		@(negedge clk_in);
		if (rd) status_read_in = 1'b1;
		else sw_reset_in = 1'b1;
		@(negedge clk_in);
		{status_read_in, sw_reset_in} = 2'h0;
	endtask : strobe
	// bounded wait for the fault pin to fall
	task automatic wait_fault(input int bound);
		n = 0;
		while (fault_n !== 1'b0 && n < bound) begin
			@(negedge clk_in);
			n++;
		end
		if (fault_n !== 1'b0) begin
			bad_count++;
			conclude();
		end
	endtask : wait_fault
	task automatic t_reset_idle();
		check({en, up, lo, flag, fault_n}, 16'h0001, "reset");
		repeat (200) @(negedge clk_in);
		check(fault_n, 1'b1, "idle");
	endtask : t_reset_idle
	// writes over both ports inside the limit, then silence
	task automatic t_timeout();
		host.write_reg(1'b0, 1'b1, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			repeat (18) @(negedge clk_in);
			host.write_reg(i[0], 1'b0, 16'h0000);
		end
		check(fault_n, 1'b1, "kept alive");
		wait_fault(80);
		check(n > 28 && n < 48, 1'b1, "expiry time");
		check(flag, 1'b1, "flag set");
	endtask : t_timeout
	task automatic t_clear();
		strobe(1'b1);
		check(flag, 1'b1, "flag sticky");
		host.write_reg(1'b1, 1'b1, 16'h0000);
		check({fault_n, flag}, 2'h3, "condition cleared");
		strobe(1'b1);
		check(flag, 1'b0, "flag read clear");
	endtask : t_clear
	// window mode: early write faults, write inside window does not
	task automatic t_window();
		host.write_reg(1'b0, 1'b1, 16'h002b);
		check({en, up, lo}, 16'h0035, "fields");
		host.write_reg(1'b0, 1'b0, 16'h0000);
		wait_fault(4);
		check(flag, 1'b1, "early write");
		host.write_reg(1'b1, 1'b0, 16'h0000);
		check(fault_n, 1'b0, "no restart");
		host.write_reg(1'b0, 1'b1, 16'h0000);
		strobe(1'b1);
		host.write_reg(1'b1, 1'b1, 16'h002b);
		repeat (16) @(negedge clk_in);
		host.write_reg(1'b0, 1'b0, 16'h0000);
		repeat (3) @(negedge clk_in);
		check({fault_n, flag}, 2'h2, "inside window");
	endtask : t_window
	// leave the window clean, disable, then enable from zero
	task automatic t_swreset();
		repeat (12) @(negedge clk_in);
		host.write_reg(1'b0, 1'b1, 16'h0000);
		host.write_reg(1'b0, 1'b1, 16'h0001);
		check(fault_n, 1'b1, "restart at enable");
		wait_fault(80);
		check(n > 28 && n < 48, 1'b1, "expiry from enable");
		strobe(1'b0);
		check({en, fault_n, flag}, 3'h3, "soft reset");
		strobe(1'b1);
		check(flag, 1'b0, "flag after reset");
	endtask : t_swreset
	// clock enable low freezes timing and fault state
	task automatic t_freeze();
		host.write_reg(1'b1, 1'b1, 16'h0001);
		clk_en = 1'b0;
		repeat (100) @(negedge clk_in);
		check({fault_n, flag, en}, 3'h5, "frozen");
		clk_en = 1'b1;
		wait_fault(80);
		check(flag, 1'b1, "fault after resume");
	endtask : t_freeze
	// hardware reset in mid-run clears condition and flag
	task automatic t_hwreset();
		@(negedge clk_in);
		resetn_in = 1'b0;
		repeat (2) @(negedge clk_in);
		resetn_in = 1'b1;
		check({en, up, lo, flag, fault_n}, 16'h0001, "hw reset");
		@(negedge clk_in);
		check({fault_n, flag}, 2'h2, "after release");
	endtask : t_hwreset
	// reset, then scenarios in order
	initial begin
		{resetn_in, sw_reset_in, status_read_in} = 3'h0;
		clk_en = 1'b1;
		bad_count = 0;
		compares = 0;
		repeat (4) @(negedge clk_in);
		resetn_in = 1'b1;
		t_reset_idle();
		t_timeout();
		t_clear();
		t_window();
		t_swreset();
		t_freeze();
		t_hwreset();
		conclude();
	end
endmodule : hcw_watchdog_tb
